// ===== verilog/irq_flags_pkg.sv
package irq_flags_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_FLAGS_ONE  = 8'h00;
    localparam logic [7:0] OFS_FLAGS_TWO  = 8'h04;
    localparam logic [7:0] OFS_ENABLE_ONE = 8'h08;
    localparam logic [7:0] OFS_ENABLE_TWO = 8'h0C;
    localparam logic [7:0] OFS_GATE_CTRL  = 8'h10;
    localparam logic [7:0] OFS_EDGE_SEL   = 8'h14;
    localparam logic [7:0] OFS_CLEAR_ONE  = 8'h18;
    localparam logic [7:0] OFS_CLEAR_TWO  = 8'h1C;
    localparam logic [7:0] OFS_MONITOR    = 8'h20;
    localparam logic [7:0] OFS_PENDING    = 8'h24;

    // First flag register field positions
    localparam int unsigned COLLISION_BIT = 5;
    localparam int unsigned SERIAL_BIT    = 4;
    localparam int unsigned CC_TWO_BIT    = 3;
    localparam int unsigned CC_ONE_BIT    = 2;
    localparam int unsigned PERIOD_BIT    = 1;
    localparam int unsigned ROLLOVER_BIT  = 0;

    // Second flag register field positions
    localparam int unsigned SWITCH_DESATURATION_BIT     = 7;
    localparam int unsigned CONV_BIT      = 6;
    localparam int unsigned OTEMP_BIT     = 4;
    localparam int unsigned OUT_HIGH_BIT  = 3;
    localparam int unsigned GATE_LOW_BIT  = 2;
    localparam int unsigned IN_HIGH_BIT   = 1;
    localparam int unsigned IN_LOW_BIT    = 0;

    // Implemented bits; the rest read zero and ignore writes
    localparam logic [7:0] IMPL_ONE = 8'h3F;
    localparam logic [7:0] IMPL_TWO = 8'hDF;

    // Monitor index i: rise select at bit 2*i, fall select at 2*i+1
    localparam int unsigned MON_CNT      = 3;
    localparam int unsigned GATE_BIT     = 0;

    // Reset values
    localparam logic [7:0] FLAGS_RST    = 8'h00;
    localparam logic [7:0] ENABLE_RST   = 8'h00;
    localparam logic       GATE_RST     = 1'b0;
    localparam logic [5:0] EDGE_SEL_RST = 6'h15;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Event pulses from peripherals, one cycle each
    typedef struct packed {
        logic desaturation;
        logic conversion_done;
        logic overtemperature;
        logic gate_supply_low;
        logic serial_collision;
        logic serial_port;
        logic capture_compare_two;
        logic capture_compare_one;
        logic period_timer_match;
        logic wide_timer_rollover;
    } periph_evt_s;

    // Voltage monitor levels, high while the condition holds
    typedef struct packed {
        logic output_high;
        logic input_high;
        logic input_low;
    } monitor_lvl_s;

    // Register write request from the bus port
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] data;
        logic [3:0]  strb;
    } wr_req_s;

    function automatic logic addr_mapped(input logic [7:0] a);
        return (a == OFS_FLAGS_ONE) || (a == OFS_FLAGS_TWO) ||
               (a == OFS_ENABLE_ONE) || (a == OFS_ENABLE_TWO) ||
               (a == OFS_GATE_CTRL) || (a == OFS_EDGE_SEL) ||
               (a == OFS_CLEAR_ONE) || (a == OFS_CLEAR_TWO) ||
               (a == OFS_MONITOR) || (a == OFS_PENDING);
    endfunction

endpackage

// ===== verilog/axil_reg_port.sv
module axil_reg_port
    import irq_flags_pkg::*;
#(
    parameter int unsigned ADDR_W = 8
) (
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output wr_req_s                wr_req,
    output logic                   wr_stb,
    output logic [7:0]             rd_addr,
    input  wire logic [31:0]       rd_data
);

    logic [ADDR_W-1:0] aw_addr_ff;
    logic [31:0]       w_data_ff;
    logic [3:0]        w_strb_ff;
    logic              rd_pend_ff;
    logic [ADDR_W-1:0] ar_addr_ff;
    logic              do_write;
    logic              aw_ok;
    logic              ar_ok;

    // Decode needs exact aligned match and zero upper address bits
    assign aw_ok    = ((aw_addr_ff >> 8) == '0) && addr_mapped(aw_addr_ff[7:0]);
    assign ar_ok    = ((ar_addr_ff >> 8) == '0) && addr_mapped(ar_addr_ff[7:0]);
    assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign rd_addr  = ar_addr_ff[7:0];

    // Write channels taken in either order; one write in flight
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            aw_addr_ff    <= '0;
            w_data_ff     <= '0;
            w_strb_ff     <= '0;
            wr_stb        <= 1'b0;
            wr_req        <= '0;
        end else begin
            wr_stb <= 1'b0;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_ff    <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_ff    <= s_axi_wdata;
                w_strb_ff    <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (do_write) begin
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
                s_axi_bvalid  <= 1'b1;
                s_axi_bresp   <= aw_ok ? RESP_OKAY : RESP_SLVERR;
                wr_stb        <= aw_ok;
                wr_req        <= '{addr: aw_addr_ff[7:0], data: w_data_ff, strb: w_strb_ff};
            end
        end
    end

    // Read: address registered, data returned two cycles after the address handshake
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= RESP_OKAY;
            s_axi_rdata   <= '0;
            rd_pend_ff    <= 1'b0;
            ar_addr_ff    <= '0;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                ar_addr_ff    <= s_axi_araddr;
                s_axi_arready <= 1'b0;
                rd_pend_ff    <= 1'b1;
            end
            if (rd_pend_ff) begin
                rd_pend_ff   <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= ar_ok ? rd_data : 32'h0000_0000;
                s_axi_rresp  <= ar_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule

// ===== verilog/peripheral_interrupt_flags.sv
// Overview of operation
// - Each flag sets on its event regardless of enables or global enable.
// - Unused bits 7:6 of first and bit 5 of second read zero.
// - First register bit 5 shows a pending serial bus collision.
// - First register bit 4 shows a pending serial port interrupt.
// - First register bits 3 and 2 set on capture/compare two and one.
// - First register bit 1 sets on period timer match, held until cleared.
// - First register bit 0 sets on wide timer rollover, held until cleared.
// - Second register bit 4 sets on overtemperature, held until cleared.
// - Second register bit 3 catches output overvoltage edge per polarity select.
// - Second register bit 2 sets on gate-drive supply undervoltage lockout.
// - Second register bit 1 catches input overvoltage lockout edge per select.
// - Second register bit 0 catches input undervoltage edge per select.
// - Interrupt raised only when flag, its enable and gate bit are set.
//
// Our own choices: register access over AXI4-Lite and the register addresses.
module peripheral_interrupt_flags
    import irq_flags_pkg::*;
#(
    parameter int unsigned ADDR_W = 8
) (
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire periph_evt_s       periph_evt,
    input  wire monitor_lvl_s      monitor_lvl,
    output logic                   periph_irq
);

    // Refuse address widths that cannot hold the map
    generate
        if (ADDR_W < 8) begin : g_bad_addr_w
            $error("ADDR_W must be at least 8");
        end
    endgenerate

    wr_req_s     wr_req;
    logic        wr_stb;
    logic [7:0]  rd_addr;
    logic [31:0] rd_data;

    // Bus port hands over single-cycle write strobes and a read address
    axil_reg_port #(
        .ADDR_W (ADDR_W)
    ) u_port (
        .mclk          (mclk),
        .sys_rst       (sys_rst),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_req        (wr_req),
        .wr_stb        (wr_stb),
        .rd_addr       (rd_addr),
        .rd_data       (rd_data)
    );

    logic [7:0]         flags_one_ff;
    logic [7:0]         flags_two_ff;
    logic [7:0]         nxt_flags_one;
    logic [7:0]         nxt_flags_two;
    logic [7:0]         enable_one_ff;
    logic [7:0]         enable_two_ff;
    logic               gate_ff;
    logic [5:0]         edge_sel_ff;
    logic [MON_CNT-1:0] mon_prev_ff;
    logic               mon_primed_ff;
    logic [MON_CNT-1:0] mon_now;
    logic [MON_CNT-1:0] mon_edge;
    logic [7:0]         set_one;
    logic [7:0]         set_two;
    logic [7:0]         pend_one;
    logic [7:0]         pend_two;
    logic               lane0;
    logic               wr_flags_one;
    logic               wr_flags_two;
    logic               wr_clear_one;
    logic               wr_clear_two;
    logic               wr_enable_one;
    logic               wr_enable_two;
    logic               wr_gate;
    logic               wr_edge_sel;

    // Only byte lane 0 carries register bits
    assign lane0         = wr_stb && wr_req.strb[0];
    assign wr_flags_one  = lane0 && (wr_req.addr == OFS_FLAGS_ONE);
    assign wr_flags_two  = lane0 && (wr_req.addr == OFS_FLAGS_TWO);
    assign wr_clear_one  = lane0 && (wr_req.addr == OFS_CLEAR_ONE);
    assign wr_clear_two  = lane0 && (wr_req.addr == OFS_CLEAR_TWO);
    assign wr_enable_one = lane0 && (wr_req.addr == OFS_ENABLE_ONE);
    assign wr_enable_two = lane0 && (wr_req.addr == OFS_ENABLE_TWO);
    assign wr_gate       = lane0 && (wr_req.addr == OFS_GATE_CTRL);
    assign wr_edge_sel   = lane0 && (wr_req.addr == OFS_EDGE_SEL);

    // Monitor levels as a vector: 0 input low, 1 input high, 2 output high
    assign mon_now = monitor_lvl;

    // Edge qualifiers per monitor, each polarity separately selectable
    generate
        for (genvar i = 0; i < MON_CNT; i++) begin : g_mon
            logic rise;
            logic fall;
            // Primed gate hides a level already present at reset release
            assign rise        = mon_now[i] && !mon_prev_ff[i] && mon_primed_ff;
            assign fall        = !mon_now[i] && mon_prev_ff[i] && mon_primed_ff;
            assign mon_edge[i] = (rise && edge_sel_ff[2*i]) ||
                                 (fall && edge_sel_ff[2*i+1]);
        end
    endgenerate

    // Previous monitor levels for edge detection
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            mon_prev_ff   <= '0;
            mon_primed_ff <= 1'b0;
        end else begin
            mon_prev_ff   <= mon_now;
            mon_primed_ff <= 1'b1;
        end
    end

    // Set terms of the first flag register
    always_comb begin
        set_one               = 8'h00;
        set_one[COLLISION_BIT] = periph_evt.serial_collision;
        set_one[SERIAL_BIT]   = periph_evt.serial_port;
        set_one[CC_TWO_BIT]   = periph_evt.capture_compare_two;
        set_one[CC_ONE_BIT]   = periph_evt.capture_compare_one;
        set_one[PERIOD_BIT]   = periph_evt.period_timer_match;
        set_one[ROLLOVER_BIT] = periph_evt.wide_timer_rollover;
    end

    // Set terms of the second flag register
    always_comb begin
        set_two               = 8'h00;
        set_two[SWITCH_DESATURATION_BIT]    = periph_evt.desaturation;
        set_two[CONV_BIT]     = periph_evt.conversion_done;
        set_two[OTEMP_BIT]    = periph_evt.overtemperature;
        set_two[OUT_HIGH_BIT] = mon_edge[2];
        set_two[GATE_LOW_BIT] = periph_evt.gate_supply_low;
        set_two[IN_HIGH_BIT]  = mon_edge[1];
        set_two[IN_LOW_BIT]   = mon_edge[0];
    end

    // Load or clear first, then OR in events so an event is never lost
    always_comb begin
        nxt_flags_one = flags_one_ff;
        if (wr_flags_one) begin
            nxt_flags_one = wr_req.data[7:0];
        end else if (wr_clear_one) begin
            nxt_flags_one = flags_one_ff & ~wr_req.data[7:0];
        end
        nxt_flags_one = (nxt_flags_one | set_one) & IMPL_ONE;
    end

    always_comb begin
        nxt_flags_two = flags_two_ff;
        if (wr_flags_two) begin
            nxt_flags_two = wr_req.data[7:0];
        end else if (wr_clear_two) begin
            nxt_flags_two = flags_two_ff & ~wr_req.data[7:0];
        end
        nxt_flags_two = (nxt_flags_two | set_two) & IMPL_TWO;
    end

    // Flags are sticky: nothing but firmware takes a bit back down
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            flags_one_ff <= FLAGS_RST;
            flags_two_ff <= FLAGS_RST;
        end else begin
            flags_one_ff <= nxt_flags_one;
            flags_two_ff <= nxt_flags_two;
        end
    end

    // Enable masks share the flag layout
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            enable_one_ff <= ENABLE_RST;
            enable_two_ff <= ENABLE_RST;
        end else begin
            if (wr_enable_one) begin
                enable_one_ff <= wr_req.data[7:0] & IMPL_ONE;
            end
            if (wr_enable_two) begin
                enable_two_ff <= wr_req.data[7:0] & IMPL_TWO;
            end
        end
    end

    // Peripheral gate and monitor polarity selects
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            gate_ff     <= GATE_RST;
            edge_sel_ff <= EDGE_SEL_RST;
        end else begin
            if (wr_gate) begin
                gate_ff <= wr_req.data[GATE_BIT];
            end
            if (wr_edge_sel) begin
                edge_sel_ff <= wr_req.data[5:0];
            end
        end
    end

    // Flags that are both set and enabled
    assign pend_one = flags_one_ff & enable_one_ff;
    assign pend_two = flags_two_ff & enable_two_ff;

    // Registered request; one cycle behind the flags, glitch free
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            periph_irq <= 1'b0;
        end else begin
            periph_irq <= gate_ff && ((|pend_one) || (|pend_two));
        end
    end

    // Read mux; reads have no side effects
    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (rd_addr)
            OFS_FLAGS_ONE:  rd_data[7:0] = flags_one_ff;
            OFS_FLAGS_TWO:  rd_data[7:0] = flags_two_ff;
            OFS_ENABLE_ONE: rd_data[7:0] = enable_one_ff;
            OFS_ENABLE_TWO: rd_data[7:0] = enable_two_ff;
            OFS_GATE_CTRL:  rd_data[GATE_BIT] = gate_ff;
            OFS_EDGE_SEL:   rd_data[5:0] = edge_sel_ff;
            OFS_CLEAR_ONE:  rd_data[7:0] = flags_one_ff;
            OFS_CLEAR_TWO:  rd_data[7:0] = flags_two_ff;
            OFS_MONITOR:    rd_data[MON_CNT-1:0] = mon_now;
            OFS_PENDING:    rd_data[15:0] = {pend_two, pend_one};
            default:        rd_data = 32'h0000_0000;
        endcase
    end

endmodule

// ===== testbench/irq_flags_assertions.sv
module irq_flags_assertions
    import irq_flags_pkg::*;
#(
    parameter int unsigned ADDR_W = 8
) (
    input wire logic              mclk,
    input wire logic              sys_rst,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic              periph_irq
);
    logic [ADDR_W-1:0] ar_q_ff;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    // Address of the read in flight; only one read is open at a time
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) ar_q_ff <= '0;
        else if (s_axi_arvalid && s_axi_arready) ar_q_ff <= s_axi_araddr;
    end

    property p_wr_answer;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
            |-> ##2 s_axi_bvalid;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
    property p_b_stands;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_stands: assert property (p_b_stands) else $error("write answer dropped");
    property p_r_stands;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_stands: assert property (p_r_stands) else $error("read answer dropped");
    property p_rd_answer;
        s_axi_arvalid && s_axi_arready |=> !s_axi_arready ##1 s_axi_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer timing");
    property p_one_unused;
        s_axi_rvalid && (ar_q_ff == OFS_FLAGS_ONE || ar_q_ff == OFS_CLEAR_ONE)
            |-> s_axi_rdata[31:6] == 26'h0 && s_axi_rresp == RESP_OKAY;
    endproperty
    a_one_unused: assert property (p_one_unused) else $error("first flags unused bits");
    property p_two_unused;
        s_axi_rvalid && (ar_q_ff == OFS_FLAGS_TWO || ar_q_ff == OFS_CLEAR_TWO)
            |-> s_axi_rdata[31:8] == 24'h0 && s_axi_rdata[5] == 1'b0;
    endproperty
    a_two_unused: assert property (p_two_unused) else $error("second flags unused bits");
    property p_unmapped;
        s_axi_rvalid && (ar_q_ff > 8'h24 || ar_q_ff[1:0] != 2'h0)
            |-> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read answer");
    // Flags only drop by a write, so the line may only fall just after a write answer
    property p_irq_held;
        $fell(periph_irq) |-> $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3);
    endproperty
    a_irq_held: assert property (p_irq_held) else $error("interrupt fell with no write");
endmodule

bind peripheral_interrupt_flags irq_flags_assertions #(.ADDR_W(ADDR_W)) u_chk (
    .mclk(mclk), .sys_rst(sys_rst), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .periph_irq(periph_irq)
);

// ===== testbench/tb.sv
module tb import irq_flags_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic         mclk = 1'b0, sys_rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0;
    logic         bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic         awready, wready, bvalid, arready, rvalid, periph_irq;
    logic [7:0]   awaddr = 8'h00, araddr = 8'h00, mb;
    logic [31:0]  wdata = 32'h0, rdata, rd_v, d;
    logic [3:0]   wstrb = 4'hF;
    logic [1:0]   bresp, rresp, resp;
    periph_evt_s  evt = '0;
    monitor_lvl_s lvl = '0;
    int           error_cnt, cmp_count, i, m, sel;
    logic [15:0]  e;
    logic [9:0]   v;

    peripheral_interrupt_flags #(.ADDR_W(8)) uut (
        .mclk(mclk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .periph_evt(evt), .monitor_lvl(lvl), .periph_irq(periph_irq)
    );

    // 40 MHz core clock
    initial begin
        forever #12.5 mclk = ~mclk;
    end

    task automatic end_sim();
        if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
        cmp_count++;
        if (s !== x) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, x, s);
        end
    endtask

    // Address and data offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] dv, input logic [3:0] s = 4'hF);
        @(posedge mclk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= dv;
        wstrb   <= s;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge mclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge mclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd_v = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic pulse(input logic [9:0] p);
        @(posedge mclk);
        evt <= p;
        @(posedge mclk);
        evt <= '0;
    endtask

    // Level change, then the second flag register must show exactly x
    task automatic mon(input logic [2:0] l, input logic [7:0] x);
        @(posedge mclk);
        lvl <= l;
        repeat (2) @(posedge mclk);
        rd(OFS_FLAGS_TWO);
        chk("monitor flag", rd_v, {24'h0, x});
        rd(OFS_MONITOR);
        chk("monitor level", rd_v, {29'h0, l});
        wr(OFS_CLEAR_TWO, 32'hFF);
    endtask

    // Write answer, flag update, then the registered line: sample after it lands
    task automatic irqc(input logic x);
        repeat (3) @(posedge mclk);
        chk("periph irq", {31'h0, periph_irq}, {31'h0, x});
    endtask

    // Event index to {second, first} flag positions
    function automatic logic [15:0] emap(input int k);
        case (k)
            9: return 16'h8000;
            8: return 16'h4000;
            7: return 16'h1000;
            6: return 16'h0400;
            default: return 16'h0001 << k;
        endcase
    endfunction

    // Hang guard, far beyond the length of the sequence
    initial begin
        repeat (40000) @(posedge mclk);
        error_cnt++;
        end_sim();
    end

    initial begin
        void'($urandom(58556));
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(OFS_FLAGS_ONE);
        chk("flags one reset", rd_v, 32'h0);
        rd(OFS_FLAGS_TWO);
        chk("flags two reset", rd_v, 32'h0);
        rd(OFS_EDGE_SEL);
        chk("edge select reset", rd_v, 32'h15);
        wr(OFS_FLAGS_ONE, 32'hFFFFFFFF);
        chk("write resp", {30'h0, resp}, {30'h0, RESP_OKAY});
        rd(OFS_FLAGS_ONE);
        chk("flags one load", rd_v, 32'h3F);
        wr(OFS_FLAGS_TWO, 32'hFFFFFFFF);
        rd(OFS_FLAGS_TWO);
        chk("flags two load", rd_v, 32'hDF);
        wr(OFS_FLAGS_ONE, 32'h0, 4'hE);
        rd(OFS_FLAGS_ONE);
        chk("strobe off", rd_v, 32'h3F);
        wr(OFS_FLAGS_ONE, 32'h0);
        wr(OFS_FLAGS_TWO, 32'h0);
        // Single events first, then random mixes, all with enables off
        for (i = 0; i < 40; i++) begin
            v = (i < 10) ? 10'(1 << i) : 10'($urandom);
            e = '0;
            for (m = 0; m < 10; m++) if (v[m]) e |= emap(m);
            pulse(v);
            rd(OFS_FLAGS_ONE);
            chk("flags one event", rd_v, {24'h0, e[7:0]});
            rd(OFS_FLAGS_TWO);
            chk("flags two event", rd_v, {24'h0, e[15:8]});
            d = $urandom;
            wr(OFS_CLEAR_ONE, d);
            rd(OFS_FLAGS_ONE);
            chk("flags one held", rd_v, {24'h0, e[7:0] & ~d[7:0]});
            wr(OFS_CLEAR_ONE, 32'hFF);
            wr(OFS_CLEAR_TWO, 32'hFF);
        end
        // Event held across a clearing write keeps the flag
        evt <= 10'h001;
        wr(OFS_CLEAR_ONE, 32'hFF);
        evt <= '0;
        rd(OFS_FLAGS_ONE);
        chk("event beats clear", rd_v, 32'h1);
        wr(OFS_ENABLE_ONE, 32'h1);
        irqc(1'b0);
        wr(OFS_GATE_CTRL, 32'h1);
        irqc(1'b1);
        rd(OFS_PENDING);
        chk("pending", rd_v, 32'h1);
        wr(OFS_ENABLE_ONE, 32'h0);
        irqc(1'b0);
        wr(OFS_ENABLE_ONE, 32'h1);
        irqc(1'b1);
        wr(OFS_CLEAR_ONE, 32'h1);
        irqc(1'b0);
        // Each monitor under rise-only and fall-only selection
        for (m = 0; m < 3; m++) begin
            mb = (m == 2) ? 8'h08 : 8'(1 << m);
            for (sel = 1; sel < 3; sel++) begin
                wr(OFS_EDGE_SEL, 32'(sel) << (2 * m));
                mon(lvl | 3'(1 << m), (sel == 1) ? mb : 8'h00);
                mon(lvl & ~3'(1 << m), (sel == 2) ? mb : 8'h00);
            end
        end
        // Second register reaches the line through its own enables
        wr(OFS_ENABLE_TWO, 32'hFF);
        pulse(10'h200);
        irqc(1'b1);
        rd(OFS_PENDING);
        chk("pending two", rd_v, 32'h8000);
        rd(8'h28);
        chk("unmapped read resp", {30'h0, resp}, {30'h0, RESP_SLVERR});
        chk("unmapped read data", rd_v, 32'h0);
        wr(8'h02, 32'hFF);
        chk("unaligned write resp", {30'h0, resp}, {30'h0, RESP_SLVERR});
        rd(OFS_FLAGS_ONE);
        chk("unaligned write ignored", rd_v, 32'h0);
        end_sim();
    end
endmodule
